// File: src/uv_alarm_monitor.sv
/*
 Under-voltage alarm monitor: per-reference enable and threshold, shared
 persistence time, alarm output, status, summary and a masked interrupt.
 Assumes RMS values arrive as a flat vector on clk and that tick_1s is a
 one-cycle strobe on clk once per second.
*/
// The address map and strobed register access were left to the implementer.
//
// Contract
// - Alarm candidate when RMS below threshold
// - Separate enable and threshold per reference
// - One persistence setting, 15 to 60 seconds
// - Trigger only after uninterrupted persistence time
// - Evaluate and count on each second tick
// - Output low idle, high while triggered
// - Readable per-reference alarm status bits
// - Alarm clears itself when voltage recovers
// - Summary state idle, armed or triggered
`timescale 1ns/1ps
module uv_alarm_monitor #(
   parameter int NREF = uv_alarm_pkg::NUM_REFS,
   parameter int VW   = uv_alarm_pkg::VOLT_W
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                ce,
   // Timing and measurement
   input  wire logic                tick_1s,
   input  wire logic [NREF*VW-1:0]  rms_volts,
   // Register port
   input  wire logic [7:0]          addr,
   input  wire logic [31:0]         wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic      [31:0]         rdata,
   // Alarm and interrupt
   output logic                     alarm_out,
   output logic                     irq
);
   localparam int AW = 4;
   localparam int PW = uv_alarm_pkg::PERSIST_W;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [VW-1:0] clamp_thr(input logic [31:0] v, input int idx);
      logic [VW-1:0] lim;
      lim = (idx < uv_alarm_pkg::REF_HALF) ? uv_alarm_pkg::LN_MAX_V : uv_alarm_pkg::LL_MAX_V;
      clamp_thr = (v > 32'(lim)) ? lim : v[VW-1:0];
   endfunction

   function automatic logic [PW-1:0] clamp_persist(input logic [31:0] v);
      if (v < 32'(uv_alarm_pkg::PERSIST_MIN_S)) begin
         clamp_persist = uv_alarm_pkg::PERSIST_MIN_S;
      end else if (v > 32'(uv_alarm_pkg::PERSIST_MAX_S)) begin
         clamp_persist = uv_alarm_pkg::PERSIST_MAX_S;
      end else begin
         clamp_persist = v[PW-1:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register port decode

   uv_alarm_pkg::bus_req_type req;
   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   logic          thr_hit;
   logic [AW-1:0] thr_idx;
   logic [7:0]    thr_off;
   assign thr_off = req.addr - uv_alarm_pkg::ADDR_THR_BASE;
   assign thr_idx = thr_off[AW+1:2];
   assign thr_hit = (req.addr >= uv_alarm_pkg::ADDR_THR_BASE) && (thr_off[1:0] == 2'b00)
                    && (int'(thr_off[7:2]) < NREF);

   ////////////////////////////////////////////////////////////////////////
   // Threshold memory; scanner walks one reference per cycle

   logic          thr_we;
   logic [VW-1:0] thr_wval;
   logic [AW-1:0] scan_r, scan_nxt;
   logic [VW-1:0] thr_rd;

   assign thr_we   = req.wr && thr_hit;
   assign thr_wval = clamp_thr(req.wdata, int'(thr_idx));

   uv_thr_mem #(.DEPTH(NREF), .WIDTH(VW), .AW(AW)) u_thr (
      .clk   (clk),
      .ce    (ce),
      .we    (thr_we),
      .waddr (thr_idx),
      .wdata (thr_wval),
      .raddr (scan_r),
      .rdata (thr_rd)
   );

   ////////////////////////////////////////////////////////////////////////
   // Control and status state

   logic [NREF-1:0]  enable_r, enable_nxt;
   logic [PW-1:0]    persist_r, persist_nxt;
   logic [NREF-1:0]  below_r, below_nxt;
   logic [NREF-1:0]  trig_r, trig_nxt;
   logic [PW-1:0]    cnt_r [NREF];
   logic [PW-1:0]    cnt_nxt [NREF];
   logic [1:0]       sum_r, sum_nxt;
   logic [1:0]       istat_r, istat_nxt;
   logic [1:0]       imask_r, imask_nxt;
   logic [31:0]      rdata_r, rdata_nxt;
   logic             alarm_r, alarm_nxt;
   logic             irq_r, irq_nxt;
   logic [AW-1:0]    scan_prev_r;
   logic             scan_valid_r;
   logic [VW-1:0]    thr_shadow_r [NREF];
   logic [VW-1:0]    thr_shadow_nxt [NREF];

   always_comb begin
      scan_nxt   = (int'(scan_r) == NREF-1) ? '0 : scan_r + 1'b1;
      enable_nxt = enable_r;
      persist_nxt = persist_r;
      below_nxt  = below_r;
      trig_nxt   = trig_r;
      imask_nxt  = imask_r;
      istat_nxt  = istat_r;
      for (int i = 0; i < NREF; i++) begin
         cnt_nxt[i]        = cnt_r[i];
         thr_shadow_nxt[i] = thr_shadow_r[i];
      end
      // Mirror memory output so every reference has a compare value
      if (scan_valid_r) begin
         thr_shadow_nxt[scan_prev_r] = thr_rd;
      end
      // Live compare only for enabled references
      for (int i = 0; i < NREF; i++) begin
         below_nxt[i] = enable_r[i] && (rms_volts[i*VW +: VW] < thr_shadow_r[i]);
      end
      if (tick_1s) begin
         for (int i = 0; i < NREF; i++) begin
            if (!below_r[i]) begin
               cnt_nxt[i]  = '0;
               trig_nxt[i] = 1'b0;
            end else if (cnt_r[i] < persist_r) begin
               cnt_nxt[i]  = cnt_r[i] + 1'b1;
               trig_nxt[i] = ((cnt_r[i] + 1'b1) >= persist_r);
            end else begin
               trig_nxt[i] = 1'b1;
            end
         end
      end
      // Software writes
      if (req.wr) begin
         unique case (req.addr)
            uv_alarm_pkg::ADDR_ENABLE:   enable_nxt = req.wdata[NREF-1:0];
            uv_alarm_pkg::ADDR_PERSIST:  persist_nxt = clamp_persist(req.wdata);
            uv_alarm_pkg::ADDR_IRQ_STAT: istat_nxt = istat_r & ~req.wdata[1:0];
            uv_alarm_pkg::ADDR_IRQ_MASK: imask_nxt = req.wdata[1:0];
            default: ;
         endcase
      end
      // Events set after clear, so a coincident event wins
      if (|(trig_nxt & ~trig_r)) begin
         istat_nxt[uv_alarm_pkg::IRQ_TRIG_BIT] = 1'b1;
      end
      if (|(trig_r & ~trig_nxt)) begin
         istat_nxt[uv_alarm_pkg::IRQ_CLEAR_BIT] = 1'b1;
      end
      alarm_nxt = |trig_nxt;
      if (|trig_nxt) begin
         sum_nxt = uv_alarm_pkg::SUM_TRIGGERED;
      end else if (|enable_nxt) begin
         sum_nxt = uv_alarm_pkg::SUM_ARMED;
      end else begin
         sum_nxt = uv_alarm_pkg::SUM_IDLE;
      end
      irq_nxt = |(istat_nxt & imask_nxt);
      // Read mux
      rdata_nxt = 32'h0000_0000;
      if (req.rd) begin
         if (thr_hit) begin
            rdata_nxt = 32'(thr_shadow_r[thr_idx]);
         end else begin
            unique case (req.addr)
               uv_alarm_pkg::ADDR_ENABLE:   rdata_nxt = 32'(enable_r);
               uv_alarm_pkg::ADDR_PERSIST:  rdata_nxt = 32'(persist_r);
               uv_alarm_pkg::ADDR_STATUS:   rdata_nxt = 32'(trig_r);
               uv_alarm_pkg::ADDR_SUMMARY:  rdata_nxt = 32'(sum_r);
               uv_alarm_pkg::ADDR_IRQ_STAT: rdata_nxt = 32'(istat_r);
               uv_alarm_pkg::ADDR_IRQ_MASK: rdata_nxt = 32'(imask_r);
               default:                     rdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scan_r       <= '0;
         scan_prev_r  <= '0;
         scan_valid_r <= 1'b0;
         enable_r     <= uv_alarm_pkg::ENABLE_RST;
         persist_r    <= uv_alarm_pkg::PERSIST_RST;
         below_r      <= '0;
         trig_r       <= '0;
         sum_r        <= uv_alarm_pkg::SUM_IDLE;
         istat_r      <= '0;
         imask_r      <= uv_alarm_pkg::MASK_RST[1:0];
         rdata_r      <= 32'h0000_0000;
         alarm_r      <= 1'b0;
         irq_r        <= 1'b0;
         for (int i = 0; i < NREF; i++) begin
            cnt_r[i]        <= '0;
            thr_shadow_r[i] <= uv_alarm_pkg::THR_RST;
         end
      end else if (ce) begin
         scan_r       <= scan_nxt;
         scan_prev_r  <= scan_r;
         scan_valid_r <= 1'b1;
         enable_r     <= enable_nxt;
         persist_r    <= persist_nxt;
         below_r      <= below_nxt;
         trig_r       <= trig_nxt;
         sum_r        <= sum_nxt;
         istat_r      <= istat_nxt;
         imask_r      <= imask_nxt;
         rdata_r      <= rdata_nxt;
         alarm_r      <= alarm_nxt;
         irq_r        <= irq_nxt;
         for (int i = 0; i < NREF; i++) begin
            cnt_r[i]        <= cnt_nxt[i];
            thr_shadow_r[i] <= thr_shadow_nxt[i];
         end
      end
   end

   assign rdata     = rdata_r;
   assign alarm_out = alarm_r;
   assign irq       = irq_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   alarm_follows_trig_a : assert property (@(posedge clk) disable iff (!rstn)
      ce |=> (alarm_out == |trig_r))
      else $error("alarm output disagrees with status");

   persist_range_a : assert property (@(posedge clk) disable iff (!rstn)
      persist_r >= uv_alarm_pkg::PERSIST_MIN_S && persist_r <= uv_alarm_pkg::PERSIST_MAX_S)
      else $error("persistence out of range");

   trig_needs_count_a : assert property (@(posedge clk) disable iff (!rstn)
      ce && tick_1s && below_r[0] && !trig_r[0] && (cnt_r[0] + 1'b1 < persist_r) |=> !trig_r[0])
      else $error("alarm triggered before persistence");

   self_clear_a : assert property (@(posedge clk) disable iff (!rstn)
      ce && tick_1s && !below_r[0] |=> !trig_r[0] && cnt_r[0] == '0)
      else $error("alarm not cleared on recovery");

   disabled_quiet_a : assert property (@(posedge clk) disable iff (!rstn)
      ce && !enable_r[0] |=> !below_r[0])
      else $error("disabled reference flagged");

   no_tick_hold_a : assert property (@(posedge clk) disable iff (!rstn)
      ce && !tick_1s |=> $stable(trig_r))
      else $error("alarm changed without tick");

   summary_idle_a : assert property (@(posedge clk) disable iff (!rstn)
      ce && enable_nxt == '0 && trig_nxt == '0 |=> sum_r == uv_alarm_pkg::SUM_IDLE)
      else $error("summary not idle");

   thr_clamp_a : assert property (@(posedge clk) disable iff (!rstn)
      thr_we |-> thr_wval <= uv_alarm_pkg::LL_MAX_V)
      else $error("threshold above ceiling");

   status_read_a : assert property (@(posedge clk) disable iff (!rstn)
      ce && rd && addr == uv_alarm_pkg::ADDR_STATUS |=> rdata == 32'($past(trig_r)))
      else $error("status readback wrong");

   // Counter never exceeds 60, so the sum cannot wrap
   trig_at_persist_a : assert property (@(posedge clk) disable iff (!rstn)
      ce && tick_1s && below_r[0] && (cnt_r[0] + 1'b1 >= persist_r) |=> trig_r[0])
      else $error("alarm late after persistence");

   all_clear_a : assert property (@(posedge clk) disable iff (!rstn)
      ce && tick_1s && below_r == '0 |=> trig_r == '0)
      else $error("alarm held after recovery");

   summary_trig_a : assert property (@(posedge clk) disable iff (!rstn)
      ce |=> (sum_r == uv_alarm_pkg::SUM_TRIGGERED) == (trig_r != '0))
      else $error("summary not triggered");

   summary_armed_a : assert property (@(posedge clk) disable iff (!rstn)
      ce |=> (sum_r == uv_alarm_pkg::SUM_ARMED) == (enable_r != '0 && trig_r == '0))
      else $error("summary not armed");

   irq_level_a : assert property (@(posedge clk) disable iff (!rstn)
      ce |=> irq == |(istat_r & imask_r))
      else $error("interrupt level wrong");

   rdata_idle_a : assert property (@(posedge clk) disable iff (!rstn)
      ce && !rd |=> rdata == 32'h0000_0000)
      else $error("read data not cleared");

   thr_clamp_ln_a : assert property (@(posedge clk) disable iff (!rstn)
      thr_we && int'(thr_idx) < uv_alarm_pkg::REF_HALF |-> thr_wval <= uv_alarm_pkg::LN_MAX_V)
      else $error("line to neutral threshold above ceiling");
endmodule

// File: src/uv_alarm_pkg.sv
/*
 Shared constants and types for the under-voltage alarm monitor.
 Assumes a 40 MHz system clock and a one-second tick strobe from elsewhere.
*/
package uv_alarm_pkg;
   localparam int NUM_REFS          = 12;
   localparam int VOLT_W            = 10;
   localparam int PERSIST_W         = 6;
   localparam int REF_HALF          = 6;

   // Threshold ceilings in volts
   localparam logic [9:0] LN_MAX_V  = 10'h15E;
   localparam logic [9:0] LL_MAX_V  = 10'h258;

   // Persistence limits in seconds
   localparam logic [5:0] PERSIST_MIN_S = 6'h0F;
   localparam logic [5:0] PERSIST_MAX_S = 6'h3C;
   localparam logic [5:0] PERSIST_RST   = 6'h0F;

   // Register offsets (byte addresses, word aligned)
   localparam logic [7:0] ADDR_ENABLE   = 8'h00;
   localparam logic [7:0] ADDR_PERSIST  = 8'h04;
   localparam logic [7:0] ADDR_STATUS   = 8'h08;
   localparam logic [7:0] ADDR_SUMMARY  = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
   localparam logic [7:0] ADDR_THR_BASE = 8'h40;

   // Reset values
   localparam logic [11:0] ENABLE_RST   = 12'h000;
   localparam logic [11:0] MASK_RST     = 12'h000;
   localparam logic [9:0]  THR_RST      = 10'h000;

   // Interrupt status bit positions
   localparam int IRQ_TRIG_BIT  = 0;
   localparam int IRQ_CLEAR_BIT = 1;
   localparam int IRQ_W         = 2;

   typedef enum logic [1:0] {
      SUM_IDLE,
      SUM_ARMED,
      SUM_TRIGGERED
   } summary_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_type;
endpackage

// File: src/uv_thr_mem.sv
/*
 Small threshold memory, one word per voltage reference, registered read.
 Assumes a single writer and one read port used by the channel scanner.
*/
`timescale 1ns/1ps
module uv_thr_mem #(
   parameter int DEPTH = 12,
   parameter int WIDTH = 10,
   parameter int AW    = 4
) (
   // Clock
   input  wire logic             clk,
   input  wire logic             ce,
   // Write port
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   // Read port
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   // No reset: contents are written by software before enabling references
   always_ff @(posedge clk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end
endmodule

// File: testbench/host_irq_model.sv
/*
 Host side model: an interrupt input fed by the alarm line.
 Assumes the alarm line is a registered level on the system clock.
*/
`timescale 1ns/1ps
module host_irq_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Interrupt input
   input  wire logic       alarm_in,
   output logic      [7:0] rise_cnt
);
   logic last_r;

   ////////////////////////////////////////////////////////////////////////////
   // Edge sensitive input, so a level held high counts once
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         last_r   <= 1'b0;
         rise_cnt <= 8'h00;
      end else begin
         last_r <= alarm_in;
         if (alarm_in && !last_r) begin
            rise_cnt <= rise_cnt + 8'h01;
         end
      end
   end
endmodule

// File: testbench/tb_top.sv
/*
 Self-checking bench for the under-voltage alarm monitor.
 Assumes the monitor's default twelve references and an external second tick.
*/
`timescale 1ns/1ps
module tb_top;
   logic                                             clk = 1'b0;
   logic                                             rstn = 1'b0;
   logic                                             ce = 1'b1;
   logic                                             tick_1s = 1'b0;
   logic                                             wr = 1'b0;
   logic                                             rd = 1'b0;
   logic [7:0]                                       addr = 8'h00;
   logic [31:0]                                      wdata = 32'h0000_0000;
   logic [uv_alarm_pkg::NUM_REFS*uv_alarm_pkg::VOLT_W-1:0] rms = '1;
   logic [31:0]                                      rdata;
   logic                                             alarm_out;
   logic                                             irq;
   logic [7:0]                                       rise_cnt;
   int                                               n_mismatch = 0;
   int                                               checks = 0;

   always #12.5 clk = ~clk;

   uv_alarm_monitor i_uv_alarm_monitor (.clk(clk), .rstn(rstn), .ce(ce), .tick_1s(tick_1s), .rms_volts(rms),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .alarm_out(alarm_out), .irq(irq));
   host_irq_model i_host_irq_model (.clk(clk), .rstn(rstn), .alarm_in(alarm_out), .rise_cnt(rise_cnt));

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      if (n_mismatch == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         tick_1s <= 1'b1;
         @(posedge clk);
         tick_1s <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask

   task automatic set_rms(input int i, input logic [9:0] v);
      @(posedge clk);
      rms[i*10+:10] <= v;
      repeat (3) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd_chk(uv_alarm_pkg::ADDR_ENABLE, 32'h0000_0000);
      rd_chk(uv_alarm_pkg::ADDR_PERSIST, 32'h0000_000F);
      rd_chk(uv_alarm_pkg::ADDR_SUMMARY, 32'h0000_0000);
      chk({31'h0, alarm_out}, 32'h0000_0000);
   endtask

   // Oversized values must come back at the ceilings
   task automatic t_clamp;
      for (int i = 0; i < 12; i++) wr_reg(8'h40 + 8'(4*i), 32'h0000_02BC);
      repeat (16) @(posedge clk);
      for (int i = 0; i < 12; i++) rd_chk(8'h40 + 8'(4*i), (i < 6) ? 32'h0000_015E : 32'h0000_0258);
      wr_reg(uv_alarm_pkg::ADDR_PERSIST, 32'h0000_0046);
      rd_chk(uv_alarm_pkg::ADDR_PERSIST, 32'h0000_003C);
      wr_reg(uv_alarm_pkg::ADDR_PERSIST, 32'h0000_0005);
      rd_chk(uv_alarm_pkg::ADDR_PERSIST, 32'h0000_000F);
      wr_reg(8'h40, 32'h0000_00C8);
      repeat (16) @(posedge clk);
   endtask

   task automatic t_trigger;
      wr_reg(uv_alarm_pkg::ADDR_ENABLE, 32'h0000_0001);
      wr_reg(uv_alarm_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
      rd_chk(uv_alarm_pkg::ADDR_SUMMARY, 32'h0000_0001);
      set_rms(0, 10'h064);
      repeat (40) @(posedge clk);
      rd_chk(uv_alarm_pkg::ADDR_STATUS, 32'h0000_0000);
      tick(14);
      rd_chk(uv_alarm_pkg::ADDR_STATUS, 32'h0000_0000);
      chk({31'h0, alarm_out}, 32'h0000_0000);
      tick(1);
      rd_chk(uv_alarm_pkg::ADDR_STATUS, 32'h0000_0001);
      chk({31'h0, alarm_out}, 32'h0000_0001);
      chk({24'h0, rise_cnt}, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0001);
      rd_chk(uv_alarm_pkg::ADDR_SUMMARY, 32'h0000_0002);
      wr_reg(uv_alarm_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
      // Equal to the threshold is not below it
      set_rms(0, 10'h0C8);
      tick(1);
      rd_chk(uv_alarm_pkg::ADDR_STATUS, 32'h0000_0000);
      chk({31'h0, alarm_out}, 32'h0000_0000);
      // Recovery is an event of its own, masked so far
      rd_chk(uv_alarm_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
      wr_reg(uv_alarm_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
      rd_chk(uv_alarm_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
      chk({31'h0, irq}, 32'h0000_0001);
      wr_reg(uv_alarm_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
      rd_chk(uv_alarm_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0000);
   endtask

   // Ticks while frozen must not advance the count
   task automatic t_freeze;
      set_rms(0, 10'h064);
      @(posedge clk);
      ce <= 1'b0;
      tick(20);
      @(posedge clk);
      ce <= 1'b1;
      rd_chk(uv_alarm_pkg::ADDR_STATUS, 32'h0000_0000);
      chk({31'h0, alarm_out}, 32'h0000_0000);
      set_rms(0, 10'h0C8);
      tick(1);
   endtask

   // A good tick or a disabled tick in mid-count starts over
   task automatic t_restart;
      set_rms(0, 10'h064);
      tick(10);
      set_rms(0, 10'h1F4);
      tick(1);
      set_rms(0, 10'h064);
      tick(10);
      wr_reg(uv_alarm_pkg::ADDR_ENABLE, 32'h0000_0000);
      tick(1);
      wr_reg(uv_alarm_pkg::ADDR_ENABLE, 32'h0000_0001);
      tick(14);
      rd_chk(uv_alarm_pkg::ADDR_STATUS, 32'h0000_0000);
      tick(1);
      rd_chk(uv_alarm_pkg::ADDR_STATUS, 32'h0000_0001);
      chk({24'h0, rise_cnt}, 32'h0000_0002);
      set_rms(0, 10'h3FF);
      tick(1);
   endtask

   task automatic t_disabled;
      set_rms(6, 10'h064);
      tick(16);
      rd_chk(uv_alarm_pkg::ADDR_STATUS, 32'h0000_0000);
      wr_reg(uv_alarm_pkg::ADDR_ENABLE, 32'h0000_0000);
      rd_chk(uv_alarm_pkg::ADDR_SUMMARY, 32'h0000_0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_clamp();
      t_trigger();
      t_freeze();
      t_restart();
      t_disabled();
      stop_test();
   end

   // Whole run is several hundred cycles
   initial begin
      #200000;
      n_mismatch++;
      stop_test();
   end
endmodule
